// [hdl/ismra_pkg.sv]
`default_nettype none
package ismra_pkg;
  // ***************************************************************
  // slave address and spaces
  // ***************************************************************
  localparam logic [3:0] ID_MEM = 4'ha;
  localparam logic [3:0] ID_REG = 4'hd;
  localparam int SA_ID_HI = 7;
  localparam int SA_ID_LO = 4;
  localparam int SA_SEL_HI = 2;
  localparam int SA_SEL_LO = 1;
  localparam int SA_RW = 0;
  localparam int MADDR_W = 15;
  localparam int MEM_DEPTH = 32768;
  localparam logic [14:0] MADDR_TOP = 15'h7fff;
  localparam int HI_KEEP = 7;
  localparam int REG_AW = 5;
  localparam int REG_DEPTH = 25;
  localparam logic [7:0] REG_TOP = 8'h18;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int T_MCLK_NS = 4;
  localparam int T_QUARTER_NS = 250;
  localparam int Q_CYC = T_QUARTER_NS / T_MCLK_NS;
  localparam logic [5:0] Q_LAST = 6'(Q_CYC - 1);

  function automatic logic [MADDR_W-1:0] inc_maddr(input logic [MADDR_W-1:0] a);
    return (a == MADDR_TOP) ? '0 : a + 15'h1;
  endfunction

  function automatic logic [REG_AW-1:0] inc_raddr(input logic [REG_AW-1:0] a);
    return (a == REG_TOP[REG_AW-1:0]) ? '0 : a + 5'h1;
  endfunction
endpackage
`default_nettype wire

// [hdl/ismra_link_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface ismra_link_if;
  logic scl;
  logic sda_m_o;
  logic sda_m_oe_n;
  logic sda_s_o;
  logic sda_s_oe_n;
  logic sda;
  // open-drain wire with pull-up: low wins
  assign sda = (sda_m_oe_n | sda_m_o) & (sda_s_oe_n | sda_s_o);
  modport master (output scl, output sda_m_o, output sda_m_oe_n, input sda);
  modport device (input scl, input sda, output sda_s_o, output sda_s_oe_n);
endinterface
`default_nettype wire

// [hdl/ismra_device.sv]
// Function
// - write: slave byte rw=0, address, data
// - write address wraps top to zero
// - unlimited write bytes, no page buffer
// - no busy time, polling always acknowledged
// - commit after eighth bit, before acknowledge
// - read starts at latched address immediately
// - increment per byte, ack fetches next
// - master ends read with nack or condition
// - read address wraps top to zero
// - repeated start keeps loaded address
// - register writes use one address byte
// - upper register address bits preferably zero
// - register reads start current, auto-increment
// - separate memory and register address latches
// - every write supplies an address first
// - address high byte first, extra bits ignored
// - memory spans 32768 byte locations
// - answers memory and register identifiers
// - register address above 18h is refused
// - select bits must match select pins
// - stop aborts operation, wait for start
`timescale 1ns/100ps
`default_nettype none
module ismra_device (
  input wire logic link_clk_i,
  input wire logic rst_i,
  ismra_link_if.device link,
  input wire logic [1:0] dev_sel_i,
  output logic wr_stb_o,
  output logic wr_reg_o,
  output logic [ismra_pkg::MADDR_W-1:0] wr_addr_o,
  output logic [7:0] wr_data_o
);
  import ismra_pkg::*;

  typedef enum logic [2:0] {
    D_IDLE = 3'h0,
    D_DEV = 3'h1,
    D_AHI = 3'h3,
    D_ALO = 3'h2,
    D_WDAT = 3'h6,
    D_RD = 3'h7
  } ismra_dst_t;

  // ***************************************************************
  // synchronisers
  // ***************************************************************
  logic [1:0] rst_s_q;
  logic [2:0] scl_s_q;
  logic [2:0] sda_s_q;
  logic [1:0] sel_s1_q;
  logic [1:0] sel_s2_q;
  logic rst_l;

  always_ff @(posedge link_clk_i) begin
    rst_s_q <= {rst_s_q[0], rst_i};
    scl_s_q <= {scl_s_q[1:0], link.scl};
    sda_s_q <= {sda_s_q[1:0], link.sda};
    sel_s1_q <= dev_sel_i;
    sel_s2_q <= sel_s1_q;
  end

  assign rst_l = rst_s_q[1];

  // edges look at stages 1 and 2 only; stage 0 is the metastable one
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic sda_v;
  assign sda_v = sda_s_q[1];
  assign rise = scl_s_q[1] & ~scl_s_q[2];
  assign fall = ~scl_s_q[1] & scl_s_q[2];
  assign start = scl_s_q[1] & scl_s_q[2] & sda_s_q[2] & ~sda_s_q[1];
  assign stop = scl_s_q[1] & scl_s_q[2] & ~sda_s_q[2] & sda_s_q[1];

  // ***************************************************************
  // storage
  // ***************************************************************
  logic [7:0] mem [MEM_DEPTH];
  logic [7:0] regs [REG_DEPTH];

  // ***************************************************************
  // protocol engine
  // ***************************************************************
  ismra_dst_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic ack_q, ack_d;
  logic mack_q, mack_d;
  logic rw_q, rw_d;
  logic regsp_q, regsp_d;
  logic [7:0] hi_q, hi_d;
  logic [7:0] sh_q, sh_d;
  logic [MADDR_W-1:0] maddr_q, maddr_d;
  logic [REG_AW-1:0] raddr_q, raddr_d;
  logic drv_q, drv_d;
  logic wr_stb_q, wr_stb_d;
  logic wr_reg_q, wr_reg_d;
  logic [MADDR_W-1:0] wr_addr_q, wr_addr_d;
  logic [7:0] wr_data_q, wr_data_d;
  logic mem_we;
  logic reg_we;
  logic [7:0] rd_byte;
  logic [3:0] sa_id;
  logic sa_hit;

  assign rd_byte = regsp_q ? regs[raddr_q] : mem[maddr_q];
  assign sa_id = sh_q[SA_ID_HI:SA_ID_LO];
  assign sa_hit = ((sa_id == ID_MEM) || (sa_id == ID_REG))
    && (sh_q[SA_SEL_HI:SA_SEL_LO] == sel_s2_q);

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    ack_d = ack_q;
    mack_d = mack_q;
    rw_d = rw_q;
    regsp_d = regsp_q;
    hi_d = hi_q;
    sh_d = sh_q;
    maddr_d = maddr_q;
    raddr_d = raddr_q;
    drv_d = drv_q;
    wr_stb_d = 1'b0;
    wr_reg_d = wr_reg_q;
    wr_addr_d = wr_addr_q;
    wr_data_d = wr_data_q;
    mem_we = 1'b0;
    reg_we = 1'b0;
    if (stop) begin
      st_d = D_IDLE;
      ack_d = 1'b0;
      drv_d = 1'b0;
    end else if (start) begin
      // a start mid-byte drops the byte unwritten; latches survive
      st_d = D_DEV;
      cnt_d = '0;
      ack_d = 1'b0;
      drv_d = 1'b0;
    end else if (st_q != D_IDLE) begin
      if (rise) begin
        if (ack_q) begin
          mack_d = sda_v;
        end else if (st_q != D_RD) begin
          sh_d = {sh_q[6:0], sda_v};
          cnt_d = cnt_q + 4'h1;
        end
      end else if (fall) begin
        if (ack_q) begin
          ack_d = 1'b0;
          drv_d = 1'b0;
          cnt_d = '0;
          if ((st_q == D_RD && !mack_q) || (st_q == D_DEV && rw_q)) begin
            st_d = D_RD;
            sh_d = rd_byte;
            drv_d = ~rd_byte[7];
            cnt_d = 4'h1;
            if (regsp_q) begin
              raddr_d = inc_raddr(raddr_q);
            end else begin
              maddr_d = inc_maddr(maddr_q);
            end
          end else if (st_q == D_RD) begin
            st_d = D_IDLE;
          end
        end else if (st_q == D_RD) begin
          if (cnt_q == BYTE_BITS) begin
            drv_d = 1'b0;
            ack_d = 1'b1;
          end else begin
            drv_d = ~sh_q[6];
            sh_d = {sh_q[6:0], 1'b0};
            cnt_d = cnt_q + 4'h1;
          end
        end else if (cnt_q == BYTE_BITS) begin
          ack_d = 1'b1;
          drv_d = 1'b1;
          unique case (st_q)
            D_DEV: begin
              if (sa_hit) begin
                // always ready: there is no write busy time
                rw_d = sh_q[SA_RW];
                regsp_d = (sa_id == ID_REG);
                if (sh_q[SA_RW]) begin
                  st_d = D_DEV;
                end else begin
                  st_d = (sa_id == ID_REG) ? D_ALO : D_AHI;
                end
              end else begin
                st_d = D_IDLE;
                ack_d = 1'b0;
                drv_d = 1'b0;
              end
            end
            D_AHI: begin
              hi_d = sh_q;
              st_d = D_ALO;
            end
            D_ALO: begin
              st_d = D_WDAT;
              if (regsp_q) begin
                // full byte compared: upper bits set are out of range too
                if (sh_q > REG_TOP) begin
                  st_d = D_IDLE;
                  ack_d = 1'b0;
                  drv_d = 1'b0;
                end else begin
                  raddr_d = sh_q[REG_AW-1:0];
                end
              end else begin
                maddr_d = {hi_q[HI_KEEP-1:0], sh_q};
              end
            end
            D_WDAT: begin
              // byte goes straight to storage, any count, no page limit
              wr_stb_d = 1'b1;
              wr_reg_d = regsp_q;
              wr_data_d = sh_q;
              if (regsp_q) begin
                reg_we = 1'b1;
                wr_addr_d = MADDR_W'(raddr_q);
                raddr_d = inc_raddr(raddr_q);
              end else begin
                mem_we = 1'b1;
                wr_addr_d = maddr_q;
                maddr_d = inc_maddr(maddr_q);
              end
            end
            default: begin
              st_d = D_IDLE;
              ack_d = 1'b0;
              drv_d = 1'b0;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (rst_l) begin
      st_q <= D_IDLE;
      cnt_q <= '0;
      ack_q <= 1'b0;
      mack_q <= 1'b1;
      rw_q <= 1'b0;
      regsp_q <= 1'b0;
      hi_q <= '0;
      sh_q <= '0;
      maddr_q <= '0;
      raddr_q <= '0;
      drv_q <= 1'b0;
      wr_stb_q <= 1'b0;
      wr_reg_q <= 1'b0;
      wr_addr_q <= '0;
      wr_data_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      ack_q <= ack_d;
      mack_q <= mack_d;
      rw_q <= rw_d;
      regsp_q <= regsp_d;
      hi_q <= hi_d;
      sh_q <= sh_d;
      maddr_q <= maddr_d;
      raddr_q <= raddr_d;
      drv_q <= drv_d;
      wr_stb_q <= wr_stb_d;
      wr_reg_q <= wr_reg_d;
      wr_addr_q <= wr_addr_d;
      wr_data_q <= wr_data_d;
    end
  end

  // arrays are not reset: contents are undefined until written
  always_ff @(posedge link_clk_i) begin
    if (mem_we) begin
      mem[maddr_q] <= sh_q;
    end
    if (reg_we) begin
      regs[raddr_q] <= sh_q;
    end
  end

  assign link.sda_s_o = 1'b0;
  assign link.sda_s_oe_n = ~drv_q;
  assign wr_stb_o = wr_stb_q;
  assign wr_reg_o = wr_reg_q;
  assign wr_addr_o = wr_addr_q;
  assign wr_data_o = wr_data_q;
endmodule
`default_nettype wire

// [hdl/ismra_master.sv]
`timescale 1ns/100ps
`default_nettype none
module ismra_master (
  input wire logic mclk_i,
  input wire logic rst_i,
  ismra_link_if.master link,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic cmd_read_i,
  input wire logic cmd_reg_i,
  input wire logic [1:0] cmd_sel_i,
  input wire logic [1:0] cmd_naddr_i,
  input wire logic [ismra_pkg::MADDR_W-1:0] cmd_addr_i,
  input wire logic [7:0] cmd_len_i,
  input wire logic cmd_rs_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  output logic done_o,
  output logic nack_o
);
  import ismra_pkg::*;

  typedef enum logic [1:0] {
    M_IDLE = 2'h0,
    M_START = 2'h1,
    M_BIT = 2'h3,
    M_STOP = 2'h2
  } ismra_mst_t;

  // ***************************************************************
  // sda synchroniser
  // ***************************************************************
  logic [1:0] sda_s_q;
  always_ff @(posedge mclk_i) begin
    sda_s_q <= {sda_s_q[0], link.sda};
  end

  // ***************************************************************
  // bit sequencer
  // ***************************************************************
  ismra_mst_t st_q, st_d;
  logic [5:0] qc_q, qc_d;
  logic [1:0] ph_q, ph_d;
  logic [3:0] bit_q, bit_d;
  logic [8:0] tx_q, tx_d;
  logic [8:0] rx_q, rx_d;
  logic [1:0] nadr_q, nadr_d;
  logic [7:0] len_q, len_d;
  logic rd_q, rd_d;
  logic rs_q, rs_d;
  logic rdb_q, rdb_d;
  logic [7:0] sa_q, sa_d;
  logic [MADDR_W-1:0] addr_q, addr_d;
  logic scl_q, scl_d;
  logic low_q, low_d;
  logic [7:0] rdat_q, rdat_d;
  logic rval_q, rval_d;
  logic done_q, done_d;
  logic nack_q, nack_d;
  logic wr_take;
  logic tick;

  assign tick = (qc_q == Q_LAST);
  assign cmd_ready_o = (st_q == M_IDLE);

  always_comb begin
    st_d = st_q;
    qc_d = tick ? '0 : qc_q + 6'h1;
    ph_d = ph_q;
    bit_d = bit_q;
    tx_d = tx_q;
    rx_d = rx_q;
    nadr_d = nadr_q;
    len_d = len_q;
    rd_d = rd_q;
    rs_d = rs_q;
    rdb_d = rdb_q;
    sa_d = sa_q;
    addr_d = addr_q;
    scl_d = scl_q;
    low_d = low_q;
    rdat_d = rdat_q;
    rval_d = 1'b0;
    done_d = 1'b0;
    nack_d = nack_q;
    wr_take = 1'b0;
    unique case (st_q)
      M_IDLE: begin
        if (cmd_valid_i) begin
          st_d = M_START;
          qc_d = '0;
          ph_d = '0;
          nack_d = 1'b0;
          rd_d = cmd_read_i;
          rs_d = cmd_rs_i;
          nadr_d = cmd_naddr_i;
          len_d = cmd_len_i;
          addr_d = cmd_addr_i;
          sa_d = {cmd_reg_i ? ID_REG : ID_MEM, 1'b0, cmd_sel_i, cmd_read_i};
        end
      end
      M_START: begin
        if (tick) begin
          ph_d = ph_q + 2'h1;
          unique case (ph_q)
            2'h0: low_d = 1'b0;
            2'h1: scl_d = 1'b1;
            2'h2: low_d = 1'b1;
            2'h3: begin
              scl_d = 1'b0;
              st_d = M_BIT;
              bit_d = '0;
              tx_d = {sa_q, 1'b1};
              rdb_d = 1'b0;
            end
          endcase
        end
      end
      M_BIT: begin
        if (tick) begin
          ph_d = ph_q + 2'h1;
          unique case (ph_q)
            2'h0: low_d = ~tx_q[8];
            2'h1: scl_d = 1'b1;
            2'h2: rx_d = {rx_q[7:0], sda_s_q[1]};
            2'h3: begin
              scl_d = 1'b0;
              if (bit_q != BYTE_BITS) begin
                tx_d = {tx_q[7:0], 1'b0};
                bit_d = bit_q + 4'h1;
              end else if (!rdb_q && rx_q[0]) begin
                nack_d = 1'b1;
                st_d = M_STOP;
              end else begin
                bit_d = '0;
                low_d = 1'b0;
                if (rdb_q) begin
                  rdat_d = rx_q[8:1];
                  rval_d = 1'b1;
                  rdb_d = 1'b0;
                end
                if (nadr_q != 2'h0) begin
                  // high byte first; top bit of the high byte sent as zero
                  tx_d = {(nadr_q == 2'h2) ? {1'b0, addr_q[MADDR_W-1:8]} : addr_q[7:0], 1'b1};
                  nadr_d = nadr_q - 2'h1;
                end else if (len_q == 8'h0) begin
                  st_d = rs_q ? M_IDLE : M_STOP;
                  done_d = rs_q;
                end else if (rd_q) begin
                  // last byte gets a nack, then the stop follows unless rs_q asks for a repeated start
                  tx_d = {8'hff, (len_q == 8'h1)};
                  len_d = len_q - 8'h1;
                  rdb_d = 1'b1;
                end else if (wr_valid_i) begin
                  wr_take = 1'b1;
                  tx_d = {wr_data_i, 1'b1};
                  len_d = len_q - 8'h1;
                end else begin
                  // starved: hold scl low until data arrives
                  // bit count parked on the ack slot so the retry reloads, not shifts
                  ph_d = 2'h3;
                  bit_d = BYTE_BITS;
                end
              end
            end
          endcase
        end
      end
      M_STOP: begin
        if (tick) begin
          ph_d = ph_q + 2'h1;
          unique case (ph_q)
            2'h0: low_d = 1'b1;
            2'h1: scl_d = 1'b1;
            2'h2: low_d = 1'b0;
            2'h3: begin
              st_d = M_IDLE;
              done_d = 1'b1;
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_q <= M_IDLE;
      qc_q <= '0;
      ph_q <= '0;
      bit_q <= '0;
      tx_q <= '0;
      rx_q <= '0;
      nadr_q <= '0;
      len_q <= '0;
      rd_q <= 1'b0;
      rs_q <= 1'b0;
      rdb_q <= 1'b0;
      sa_q <= '0;
      addr_q <= '0;
      scl_q <= 1'b1;
      low_q <= 1'b0;
      rdat_q <= '0;
      rval_q <= 1'b0;
      done_q <= 1'b0;
      nack_q <= 1'b0;
    end else begin
      st_q <= st_d;
      qc_q <= qc_d;
      ph_q <= ph_d;
      bit_q <= bit_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
      nadr_q <= nadr_d;
      len_q <= len_d;
      rd_q <= rd_d;
      rs_q <= rs_d;
      rdb_q <= rdb_d;
      sa_q <= sa_d;
      addr_q <= addr_d;
      scl_q <= scl_d;
      low_q <= low_d;
      rdat_q <= rdat_d;
      rval_q <= rval_d;
      done_q <= done_d;
      nack_q <= nack_d;
    end
  end

  assign link.scl = scl_q;
  assign link.sda_m_o = 1'b0;
  assign link.sda_m_oe_n = ~low_q;
  assign wr_ready_o = wr_take;
  assign rd_data_o = rdat_q;
  assign rd_valid_o = rval_q;
  assign done_o = done_q;
  assign nack_o = nack_q;
endmodule
`default_nettype wire

// [sim/ismra_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
module ismra_monitor (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [1:0] dev_sel,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_m_oe_n,
  input wire logic sda_s_oe_n
);
  import ismra_pkg::*;
  // ***************************************************************
  // bus decoder
  // ***************************************************************
  // sampled in the master domain; the master makes scl there
  logic scl_q, sda_q, rd_q;
  logic [3:0] cnt_q;
  logic [1:0] bidx_q;
  logic [7:0] sh_q, hdr_q;
  wire logic rise = scl && !scl_q;
  wire logic start_ev = scl && scl_q && sda_q && !sda;
  wire logic stop_ev = scl && scl_q && !sda_q && sda;
  wire logic slot = rise && (cnt_q == 4'h8);
  wire logic id_ok = (sh_q[7:4] == ID_MEM) || (sh_q[7:4] == ID_REG);
  wire logic sel_ok = sh_q[2:1] == dev_sel;
  wire logic hdr_wr = (hdr_q[2:1] == dev_sel) && !hdr_q[0];
  always_ff @(posedge mclk_i) begin
    scl_q <= scl;
    sda_q <= sda;
    if (rst_i || start_ev || stop_ev) begin
      cnt_q <= 4'h0;
      bidx_q <= 2'h0;
      rd_q <= 1'b0;
      hdr_q <= 8'h00;
    end else if (slot) begin
      cnt_q <= 4'h0;
      if (bidx_q != 2'h3) begin
        bidx_q <= bidx_q + 2'h1;
      end
      if (bidx_q == 2'h0) begin
        hdr_q <= sh_q;
      end
      rd_q <= (bidx_q == 2'h0) ? (sh_q[0] && !sda) : (rd_q && !sda);
    end else if (rise) begin
      cnt_q <= cnt_q + 4'h1;
      sh_q <= {sh_q[6:0], sda};
    end
  end
  // ***************************************************************
  // properties
  // ***************************************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_hdr_slot;
    slot && (bidx_q == 2'h0);
  endsequence
  sequence s_stop;
    stop_ev;
  endsequence
  a_foreign_addr_quiet: assert property (s_hdr_slot ##0 (!id_ok || !sel_ok) |-> sda)
    else $error("foreign address acknowledged");
  a_own_addr_ack: assert property (s_hdr_slot ##0 (id_ok && sel_ok) |-> !sda)
    else $error("own address not acknowledged");
  a_reg_addr_nack: assert property (slot && (bidx_q == 2'h1) && hdr_wr
    && (hdr_q[7:4] == ID_REG) && (sh_q > REG_TOP) |-> sda)
    else $error("bad register address acknowledged");
  a_reg_addr_ack: assert property (slot && (bidx_q == 2'h1) && hdr_wr
    && (hdr_q[7:4] == ID_REG) && (sh_q <= REG_TOP) |-> !sda)
    else $error("register address refused");
  a_mem_bytes_ack: assert property (slot && (bidx_q != 2'h0) && hdr_wr
    && (hdr_q[7:4] == ID_MEM) |-> !sda)
    else $error("memory write byte refused");
  a_read_master_quiet: assert property (rise && rd_q && (cnt_q != 4'h8) |-> sda_m_oe_n)
    else $error("master drives during read data");
  a_dev_steady_high: assert property (scl && scl_q |-> $stable(sda_s_oe_n))
    else $error("device changed data while clock high");
  a_stop_frees_bus: assert property (s_stop |=> sda [*8])
    else $error("bus held after stop");
endmodule
`default_nettype wire

// [sim/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import ismra_pkg::*;
  localparam logic [1:0] SEL = 2'h2;
  logic mclk_i = 1'b0, link_clk_i = 1'b0, rst_i = 1'b1;
  logic cmd_valid_i = 1'b0, cmd_read_i = 1'b0, cmd_reg_i = 1'b0, cmd_rs_i = 1'b0;
  logic wr_valid_i = 1'b0;
  logic [1:0] cmd_sel_i = 2'h0, cmd_naddr_i = 2'h0;
  logic [1:0] dev_sel_i = SEL;
  logic [14:0] cmd_addr_i = 15'h0;
  logic [7:0] cmd_len_i = 8'h0, wr_data_i = 8'h0;
  logic cmd_ready_o, wr_ready_o, rd_valid_o, done_o, nack_o, wr_stb_o, wr_reg_o;
  logic [14:0] wr_addr_o;
  logic [7:0] rd_data_o, wr_data_o;
  logic [7:0] tx[$], rq[$];
  logic [23:0] wq[$];
  int n_mismatch, compares;
  ismra_link_if link_i();
  ismra_master ismra_master_i (.mclk_i, .rst_i, .link(link_i), .cmd_valid_i, .cmd_ready_o,
    .cmd_read_i, .cmd_reg_i, .cmd_sel_i, .cmd_naddr_i, .cmd_addr_i, .cmd_len_i, .cmd_rs_i,
    .wr_data_i, .wr_valid_i, .wr_ready_o, .rd_data_o, .rd_valid_o, .done_o, .nack_o);
  ismra_device ismra_device_i (.link_clk_i, .rst_i, .link(link_i), .dev_sel_i,
    .wr_stb_o, .wr_reg_o, .wr_addr_o, .wr_data_o);
  ismra_monitor ismra_monitor_i (.mclk_i, .rst_i, .dev_sel(dev_sel_i), .scl(link_i.scl),
    .sda(link_i.sda), .sda_m_oe_n(link_i.sda_m_oe_n), .sda_s_oe_n(link_i.sda_s_oe_n));
  // ***************************************************************
  // clocks and capture
  // ***************************************************************
  always #2 mclk_i = ~mclk_i;
  always #15 link_clk_i = ~link_clk_i;
  always @(negedge link_clk_i) begin
    if (wr_stb_o === 1'b1) begin
      wq.push_back({wr_reg_o, wr_addr_o, wr_data_o});
    end
  end
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic run_cmd(input logic rd, input logic rg, input logic [1:0] sel,
    input logic [1:0] na, input logic [14:0] a, input logic [7:0] n, input logic rs);
    int k;
    int w;
    k = 0;
    rq.delete();
    wq.delete();
    @(posedge mclk_i);
    cmd_valid_i <= 1'b1;
    cmd_read_i <= rd;
    cmd_reg_i <= rg;
    cmd_sel_i <= sel;
    cmd_naddr_i <= na;
    cmd_addr_i <= a;
    cmd_len_i <= n;
    cmd_rs_i <= rs;
    wr_valid_i <= !rd && (tx.size() > 0);
    wr_data_i <= (tx.size() > 0) ? tx[0] : 8'h00;
    @(posedge mclk_i);
    cmd_valid_i <= 1'b0;
    for (w = 0; w < 40000; w++) begin
      @(negedge mclk_i);
      if (rd_valid_o === 1'b1) rq.push_back(rd_data_o);
      if (done_o === 1'b1) break;
      if (wr_ready_o === 1'b1) begin
        k++;
        @(posedge mclk_i);
        wr_data_i <= (k < tx.size()) ? tx[k] : 8'h00;
        wr_valid_i <= k < tx.size();
      end
    end
    if (w == 40000) begin
      n_mismatch++;
      tally_and_finish();
    end
    check(24'(cmd_ready_o), 24'h1);
  endtask
  // ***************************************************************
  // scenarios
  // ***************************************************************
  task automatic t_write_wrap;
    int i;
    tx = {8'h11, 8'h22, 8'h33, 8'h44};
    run_cmd(1'b0, 1'b0, SEL, 2'h2, 15'h7ffe, 8'h4, 1'b0);
    check(24'(nack_o), 24'h0);
    check(24'(wq.size()), 24'h4);
    for (i = 0; i < 4; i++) begin
      check(wq[i], {1'b0, 15'(15'h7ffe + i), tx[i]});
    end
    tx.delete();
    // polling right after a write must never see a busy device
    run_cmd(1'b0, 1'b0, SEL, 2'h0, 15'h0, 8'h0, 1'b0);
    check(24'(nack_o), 24'h0);
  endtask
  task automatic t_sel_read;
    run_cmd(1'b0, 1'b0, SEL, 2'h2, 15'h7ffe, 8'h0, 1'b1);
    check(24'(wq.size()), 24'h0);
    run_cmd(1'b1, 1'b0, SEL, 2'h0, 15'h0, 8'h3, 1'b0);
    check(24'(rq.size()), 24'h3);
    check(24'(rq[0]), 24'h11);
    check(24'(rq[1]), 24'h22);
    check(24'(rq[2]), 24'h33);
  endtask
  task automatic t_reg_space;
    int i;
    tx = {8'h5a, 8'ha5};
    run_cmd(1'b0, 1'b1, SEL, 2'h1, 15'h0018, 8'h2, 1'b0);
    check(24'(nack_o), 24'h0);
    check(wq[0], {1'b1, 15'h0018, 8'h5a});
    check(wq[1], {1'b1, 15'h0000, 8'ha5});
    tx.delete();
    for (i = 0; i < 2; i++) begin
      run_cmd(1'b0, 1'b1, SEL, 2'h1, (i == 0) ? 15'h0019 : 15'h00ff, 8'h0, 1'b0);
      check(24'(nack_o), 24'h1);
    end
    // reload the register pointer, then read across its wrap point
    run_cmd(1'b0, 1'b1, SEL, 2'h1, 15'h0018, 8'h0, 1'b1);
    check(24'(wq.size()), 24'h0);
    run_cmd(1'b1, 1'b1, SEL, 2'h0, 15'h0, 8'h2, 1'b0);
    check(24'(nack_o), 24'h0);
    check(24'(rq.size()), 24'h2);
    check(24'(rq[0]), 24'h5a);
    check(24'(rq[1]), 24'ha5);
  endtask
  task automatic t_mem_resume;
    // register traffic in between must not move the memory pointer
    run_cmd(1'b1, 1'b0, SEL, 2'h0, 15'h0, 8'h1, 1'b0);
    check(24'(rq[0]), 24'h44);
  endtask
  task automatic t_wrong_sel;
    run_cmd(1'b0, 1'b0, ~SEL, 2'h0, 15'h0, 8'h0, 1'b0);
    check(24'(nack_o), 24'h1);
    run_cmd(1'b1, 1'b1, 2'h1, 2'h0, 15'h0, 8'h1, 1'b0);
    check(24'(nack_o), 24'h1);
    // select pins moved: the old refused code must now be answered
    @(posedge mclk_i);
    dev_sel_i <= ~SEL;
    repeat (40) @(posedge mclk_i);
    run_cmd(1'b0, 1'b0, ~SEL, 2'h0, 15'h0, 8'h0, 1'b0);
    check(24'(nack_o), 24'h0);
  endtask
  initial begin
    // held 32 cycles so the slow link side sees four edges in reset
    repeat (32) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (40) @(posedge mclk_i);
    t_write_wrap();
    t_sel_read();
    t_reg_space();
    t_mem_resume();
    t_wrong_sel();
    tally_and_finish();
  end
endmodule
`default_nettype wire
